// ---- hdl/spt_pkg.sv ----
// Purpose: shared constants for the scan pulse and timer units
// Assumes: one 10 MHz clock, scan strobe from the sequencer, time-base tick from the divider in spt_units
// Notes:   preset and elapsed values are 16-bit words, preset kept to 0..32767
`default_nettype none
package spt_pkg;
  localparam int unsigned TIME_W       = 16;
  localparam logic [15:0] PRESET_MAX   = 16'h7FFF;
  localparam logic [15:0] ELAPSED_RST  = 16'h0000;
  localparam logic        BIT_RST      = 1'b0;
  localparam int unsigned TICK_NS      = 10000000;
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned TICK_CYCLES  = TICK_NS / CLK_NS;
  typedef enum logic [1:0] {
    SPT_MODE_ON_DELAY,
    SPT_MODE_OFF_DELAY,
    SPT_MODE_SINGLE_SHOT
  } spt_mode_t;
endpackage : spt_pkg
`default_nettype wire

// ---- hdl/spt_timer.sv ----
// Purpose: one scan-evaluated timer (on-delay, off-delay or single shot)
// Assumes: scan_stb and tick_en are one-cycle pulses on ref_clk
// Notes:   the elapsed value saturates at preset, it never wraps
`default_nettype none
module spt_timer #(
  parameter spt_pkg::spt_mode_t MODE = spt_pkg::SPT_MODE_ON_DELAY
) (
  input  wire logic        ref_clk,     // clock
  input  wire logic        reset,       // async reset, high
  input  wire logic        scan_stb,    // once per scan
  input  wire logic        tick_en,     // time-base tick
  input  wire logic        rung_in,     // input rung
  input  wire logic [15:0] preset,      // preset time
  output logic      [15:0] elapsed,     // timer register
  output logic             timer_bit,   // timer device bit
  output logic             rung_out     // output rung
);
  logic        prev_reg;
  logic        run_reg;
  logic        out_reg;
  logic [15:0] elapsed_reg;
  logic        tick_pend_reg;
  wire         rise = rung_in & ~prev_reg;
  wire         fall = ~rung_in & prev_reg;
  wire [15:0]  el_inc = elapsed_reg + 16'h0001;
  wire         done_now = (elapsed_reg >= preset);
  // a tick between scans is held for the next scan; several ticks between scans count as one
  wire         adv = run_reg & tick_pend_reg;
  wire [15:0]  el_step = adv ? el_inc : elapsed_reg;
  wire         reach = (el_step >= preset);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_pend_reg <= 1'b0;
    end else if (scan_stb) begin
      tick_pend_reg <= tick_en;
    end else if (tick_en) begin
      tick_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev_reg    <= spt_pkg::BIT_RST;
      run_reg     <= 1'b0;
      out_reg     <= spt_pkg::BIT_RST;
      elapsed_reg <= spt_pkg::ELAPSED_RST;
    end else if (scan_stb) begin
      prev_reg <= rung_in; // RULE18
      unique case (MODE)
        spt_pkg::SPT_MODE_ON_DELAY: begin
          if (!rung_in) begin
            elapsed_reg <= spt_pkg::ELAPSED_RST; // RULE10
            run_reg     <= 1'b0;
            out_reg     <= 1'b0;
          end else if (rise) begin
            elapsed_reg <= spt_pkg::ELAPSED_RST; // RULE8
            run_reg     <= ~(preset == 16'h0000);
            out_reg     <= (preset == 16'h0000);
          end else begin
            elapsed_reg <= el_step; // RULE19
            run_reg     <= run_reg & ~reach;
            out_reg     <= out_reg | reach | done_now; // RULE9
          end
        end
        spt_pkg::SPT_MODE_OFF_DELAY: begin
          if (rung_in) begin
            elapsed_reg <= spt_pkg::ELAPSED_RST; // RULE14
            run_reg     <= 1'b0;
            out_reg     <= 1'b1; // RULE12
          end else if (fall) begin
            elapsed_reg <= spt_pkg::ELAPSED_RST; // RULE13
            run_reg     <= ~(preset == 16'h0000);
            out_reg     <= ~(preset == 16'h0000);
          end else begin
            elapsed_reg <= el_step;
            run_reg     <= run_reg & ~reach;
            out_reg     <= out_reg & ~reach; // RULE13
          end
        end
        spt_pkg::SPT_MODE_SINGLE_SHOT: begin
          if (rise && !run_reg) begin
            elapsed_reg <= spt_pkg::ELAPSED_RST; // RULE16
            run_reg     <= ~(preset == 16'h0000);
            out_reg     <= ~(preset == 16'h0000);
          end else begin
            // shot runs to its end whatever the input does after rising
            elapsed_reg <= el_step;
            run_reg     <= run_reg & ~reach;
            out_reg     <= out_reg & ~reach; // RULE17
          end
        end
        default: begin
          run_reg <= 1'b0;
        end
      endcase
    end
  end

  assign elapsed   = elapsed_reg;
  assign timer_bit = out_reg;
  assign rung_out  = out_reg;
endmodule : spt_timer
`default_nettype wire

// ---- hdl/spt_units.sv ----
// Purpose: pulse contact, pulse coils and three timers of the ladder engine
// Assumes: scan_stb from the scan sequencer; rung inputs settle before it
// Notes:   every result is latched at the scan strobe and held for the scan
//
// What this block does
// RULE1: negative pulse contact outputs ON when rung ON and device fell.
// RULE2: negative pulse contact OFF when rung OFF or device currently ON.
// RULE3: positive pulse coil sets target ON one scan on rung rising.
// RULE4: positive pulse coil writes OFF otherwise.
// RULE5: negative pulse coil sets target ON one scan on rung falling.
// RULE6: negative pulse coil writes OFF otherwise.
// RULE7: program uses at most 2048 edge-detecting instances overall.
// RULE8: on-delay timer starts elapsed count when its input rises.
// RULE9: on-delay output ON once elapsed reaches preset; counting stops.
// RULE10: on-delay input OFF clears elapsed to 0 and output OFF.
// RULE11: preset operand lies within 0 to 32767.
// RULE12: off-delay output and timer bit turn ON at input rise.
// RULE13: off-delay counts after input falls, output OFF at preset.
// RULE14: off-delay holds output ON and does not count while input ON.
// RULE15: one timer register serves only one timer instance.
// RULE16: single-shot output ON and counting starts at input rise.
// RULE17: single-shot output OFF and counting stops at preset.
// RULE18: every unit samples inputs each scan as previous-scan state.
// RULE19: elapsed time advances one count per time-base tick; code adds at most one count per scan, several ticks between scans count as one.
`default_nettype none
module spt_units #(
  parameter int unsigned TICK_CYCLES = spt_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk,       // 10 MHz clock
  input  wire logic        reset,         // async reset, high
  input  wire logic        scan_stb,      // one-cycle scan strobe
  input  wire logic        npc_rung,      // neg pulse contact input rung
  input  wire logic        npc_dev,       // neg pulse contact device
  output logic             npc_out,       // neg pulse contact output rung
  input  wire logic        ppc_rung,      // pos pulse coil input rung
  output logic             ppc_dev,       // pos pulse coil target device
  input  wire logic        npl_rung,      // neg pulse coil input rung
  output logic             npl_dev,       // neg pulse coil target device
  input  wire logic        ond_rung,      // on_delay_timer input
  input  wire logic [15:0] ond_preset,    // on_delay_timer preset
  output logic      [15:0] ond_elapsed,   // on_delay_timer register
  output logic             ond_bit,       // on_delay_timer device bit
  output logic             ond_out,       // on_delay_timer output rung
  input  wire logic        ofd_rung,      // off_delay_timer input
  input  wire logic [15:0] ofd_preset,    // off_delay_timer preset
  output logic      [15:0] ofd_elapsed,   // off_delay_timer register
  output logic             ofd_bit,       // off_delay_timer device bit
  output logic             ofd_out,       // off_delay_timer output rung
  input  wire logic        ssh_rung,      // single shot input
  input  wire logic [15:0] ssh_preset,    // single shot preset
  output logic      [15:0] ssh_elapsed,   // single shot register
  output logic             ssh_bit,       // single shot device bit
  output logic             ssh_out,       // single shot output rung
  output logic             tick_en        // time-base tick pulse
);
  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
  logic [DIV_W-1:0] div_reg;
  logic             tick_reg;
  logic             npc_dev_prev_reg;
  logic             ppc_prev_reg;
  logic             npl_prev_reg;
  logic             npc_out_reg;
  logic             ppc_dev_reg;
  logic             npl_dev_reg;

  // preset kept in range; upper bit ignored rather than trusted
  wire [15:0] ond_pre = ond_preset & spt_pkg::PRESET_MAX; // RULE11
  wire [15:0] ofd_pre = ofd_preset & spt_pkg::PRESET_MAX;
  wire [15:0] ssh_pre = ssh_preset & spt_pkg::PRESET_MAX;
  wire div_end = (div_reg == DIV_W'(TICK_CYCLES - 1));

  wire npc_next = npc_rung & ~npc_dev & npc_dev_prev_reg; // RULE1 RULE2
  wire ppc_next = ppc_rung & ~ppc_prev_reg; // RULE3 RULE4
  wire npl_next = ~npl_rung & npl_prev_reg; // RULE5 RULE6

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? '0 : div_reg + DIV_W'(1);
      tick_reg <= div_end; // RULE19
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      npc_dev_prev_reg <= spt_pkg::BIT_RST;
      ppc_prev_reg     <= spt_pkg::BIT_RST;
      npl_prev_reg     <= spt_pkg::BIT_RST;
      npc_out_reg      <= spt_pkg::BIT_RST;
      ppc_dev_reg      <= spt_pkg::BIT_RST;
      npl_dev_reg      <= spt_pkg::BIT_RST;
    end else if (scan_stb) begin
      npc_dev_prev_reg <= npc_dev; // RULE18
      ppc_prev_reg     <= ppc_rung;
      npl_prev_reg     <= npl_rung;
      npc_out_reg      <= npc_next;
      ppc_dev_reg      <= ppc_next;
      npl_dev_reg      <= npl_next;
    end
  end

  spt_timer #(.MODE(spt_pkg::SPT_MODE_ON_DELAY)) u_ond (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .scan_stb  (scan_stb),
    .tick_en   (tick_reg),
    .rung_in   (ond_rung),
    .preset    (ond_pre),
    .elapsed   (ond_elapsed),
    .timer_bit (ond_bit),
    .rung_out  (ond_out)
  );

  spt_timer #(.MODE(spt_pkg::SPT_MODE_OFF_DELAY)) u_ofd (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .scan_stb  (scan_stb),
    .tick_en   (tick_reg),
    .rung_in   (ofd_rung),
    .preset    (ofd_pre),
    .elapsed   (ofd_elapsed),
    .timer_bit (ofd_bit),
    .rung_out  (ofd_out)
  );

  spt_timer #(.MODE(spt_pkg::SPT_MODE_SINGLE_SHOT)) u_ssh (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .scan_stb  (scan_stb),
    .tick_en   (tick_reg),
    .rung_in   (ssh_rung),
    .preset    (ssh_pre),
    .elapsed   (ssh_elapsed),
    .timer_bit (ssh_bit),
    .rung_out  (ssh_out)
  );

  assign npc_out = npc_out_reg;
  assign ppc_dev = ppc_dev_reg;
  assign npl_dev = npl_dev_reg;
  assign tick_en = tick_reg;
endmodule : spt_units
`default_nettype wire

// ---- tb/spt_units_props.sv ----
// Purpose: port-level checks for spt_units
// Assumes: one clock, async high reset, tick every TICK_CYCLES clocks
// Notes:   unit results may move only at a scan edge
`default_nettype none
module spt_units_props #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic        ref_clk,      // clock
  input wire logic        reset,        // async reset, high
  input wire logic        scan_stb,     // scan strobe
  input wire logic        tick_en,      // time-base tick
  input wire logic        npc_rung,     // contact rung
  input wire logic        npc_dev,      // contact device
  input wire logic        npc_out,      // contact output
  input wire logic        ppc_rung,     // pos coil rung
  input wire logic        ppc_dev,      // pos coil target
  input wire logic        npl_rung,     // neg coil rung
  input wire logic        npl_dev,      // neg coil target
  input wire logic        ond_rung,     // on-delay input
  input wire logic        ond_out,      // on-delay output
  input wire logic        ofd_rung,     // off-delay input
  input wire logic        ofd_out,      // off-delay output
  input wire logic        ofd_bit,      // off-delay device bit
  input wire logic        ssh_out,      // single shot output
  input wire logic        ssh_bit,      // single shot device bit
  input wire logic [15:0] ssh_preset,   // single shot preset
  input wire logic [15:0] ond_elapsed,  // on-delay register
  input wire logic [15:0] ofd_elapsed,  // off-delay register
  input wire logic [15:0] ssh_elapsed   // single shot register
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // gap stays 0 until the first tick, so the first period is not judged
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) gap <= 0;
    else gap <= tick_en ? 1 : ((gap == 0) ? 0 : gap + 1);
  end
  a_tick_gap: assert property (gap != 0 |-> (tick_en == (gap == TICK_CYCLES)))
    else $error("tick spacing wrong");
  a_npc_off: assert property (scan_stb && (!npc_rung || npc_dev) |=> !npc_out)
    else $error("contact on while rung off or device on");
  a_ppc_once: assert property (scan_stb && ppc_dev |=> !ppc_dev)
    else $error("pos coil on for two scans");
  a_ppc_off: assert property (scan_stb && !ppc_rung |=> !ppc_dev)
    else $error("pos coil on with rung off");
  a_npl_once: assert property (scan_stb && npl_dev |=> !npl_dev)
    else $error("neg coil on for two scans");
  a_npl_off: assert property (scan_stb && npl_rung |=> !npl_dev)
    else $error("neg coil on with rung on");
  a_ond_clear: assert property (scan_stb && !ond_rung |=>
    !ond_out && ond_elapsed == 16'h0000)
    else $error("on-delay not cleared");
  a_ofd_hold: assert property (scan_stb && ofd_rung |=>
    ofd_out && ofd_bit && ofd_elapsed == 16'h0000)
    else $error("off-delay not held on");
  a_scan_hold: assert property (!scan_stb |=>
    $stable(npc_out) && $stable(ond_elapsed) && $stable(ssh_out))
    else $error("result moved between scans");
  // while the shot is on its elapsed time must still be short of preset
  a_ssh_bit: assert property (ssh_bit == ssh_out &&
    (!ssh_out || ssh_elapsed < (ssh_preset & 16'h7FFF)))
    else $error("single shot bit or elapsed wrong");
endmodule : spt_units_props
`default_nettype wire

// ---- tb/spt_seq_model.sv ----
// Purpose: scan sequencer stand-in driving the scan strobe
// Assumes: tick_en pulses are several clocks apart
// Notes:   strobes the edge after a tick so a scan never meets a tick
`default_nettype none
module spt_seq_model (
  input  wire logic ref_clk,  // clock
  input  wire logic reset,    // async reset, high
  input  wire logic tick_en,  // time base from the block
  input  wire logic dbl,      // ask for a back-to-back scan
  output var  logic scan_stb  // scan strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic again_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scan_stb  <= 1'b0;
      again_reg <= 1'b0;
    end else begin
      scan_stb  <= tick_en | (scan_stb & dbl & ~again_reg);
      again_reg <= scan_stb & ~again_reg;
    end
  end
endmodule : spt_seq_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for spt_units
// Assumes: TICK_CYCLES of 4, scans issued by the sequencer model
// Notes:   an integer reference model predicts every scan result
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset = 1, scan_stb, tick_en, dbl = 0;
  logic npc_rung = 0, npc_dev = 0, ppc_rung = 0, npl_rung = 0;
  logic ond_rung = 0, ofd_rung = 0, ssh_rung = 0;
  logic [15:0] ond_preset = 16'h0001, ofd_preset = 16'h0001, ssh_preset = 16'h0001;
  logic npc_out, ppc_dev, npl_dev, ond_bit, ond_out, ofd_bit, ofd_out, ssh_bit, ssh_out;
  logic [15:0] ond_elapsed, ofd_elapsed, ssh_elapsed;
  int n_fail = 0, n_tests = 0, p;
  int pd, pp, pn, po, pf, ps, tk, eo, ef, es, xo, xf, xs, xc, xp, xn;
  always #50 ref_clk = ~ref_clk;
  spt_units #(.TICK_CYCLES(4)) spt_units_i (.*);
  spt_seq_model spt_seq_model_i (.*);
  task automatic model();
    xc = npc_rung && pd && !npc_dev;
    xp = ppc_rung && !pp;
    xn = !npl_rung && pn;
    p = ond_preset[14:0];
    if (!ond_rung) begin eo = 0; xo = 0; end
    else if (!po) begin eo = 0; xo = (p == 0); end
    else begin if (!xo && tk) eo++; xo = (eo >= p); end
    p = ofd_preset[14:0];
    if (ofd_rung) begin ef = 0; xf = 1; end
    else if (pf) begin ef = 0; xf = (p != 0); end
    else if (xf) begin if (tk) ef++; xf = (ef < p); end
    p = ssh_preset[14:0];
    if (ssh_rung && !ps && !xs) begin es = 0; xs = (p != 0); end
    else if (xs) begin if (tk) es++; xs = (es < p); end
    // one by one: a packed copy into ints would pad and lose the bits
    pd = npc_dev;
    pp = ppc_rung;
    pn = npl_rung;
    po = ond_rung;
    pf = ofd_rung;
    ps = ssh_rung;
    tk = 0;
  endtask : model
  task automatic cb(input logic [1:0] got, input int exp, input string what);
    n_tests++;
    if (got !== 2'(exp)) begin n_fail++; $display("Error %0t: %s got %b", $time, what, got); end
  endtask : cb
  task automatic cw(input logic [15:0] got, input int exp, input string what);
    n_tests++;
    if (got !== 16'(exp)) begin n_fail++; $display("Error %0t: %s got %0d", $time, what, got); end
  endtask : cw
  task automatic step();
    @(posedge ref_clk);
    if (tick_en) tk = 1;
    if (scan_stb) begin
      model();
      npc_rung <= $urandom_range(3) != 0;
      npc_dev <= 1'($urandom);
      ppc_rung <= 1'($urandom);
      npl_rung <= 1'($urandom);
      dbl <= 1'($urandom);
      if ($urandom_range(5) == 0) ond_rung <= !ond_rung;
      if ($urandom_range(5) == 0) ofd_rung <= !ofd_rung;
      if ($urandom_range(5) == 0) ssh_rung <= !ssh_rung;
      @(negedge ref_clk);
      cb(npc_out, xc, "contact");
      cb(ppc_dev, xp, "pos coil");
      cb(npl_dev, xn, "neg coil");
      cb({ond_out, ond_bit}, xo * 3, "on-delay");
      cw(ond_elapsed, eo, "on-delay elapsed");
      cb({ofd_out, ofd_bit}, xf * 3, "off-delay");
      cw(ofd_elapsed, ef, "off-delay elapsed");
      cb({ssh_out, ssh_bit}, xs * 3, "shot");
      cw(ssh_elapsed, es, "shot elapsed");
    end
  endtask : step
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    void'($urandom(32'h52AD6E96));
    for (int t = 1; t <= 4; t++) begin
      // a test may end at a falling edge; reset only moves on a rising one
      if (t > 1) @(posedge ref_clk);
      reset <= 1;
      ond_preset <= {1'b0, 15'($urandom_range(5))};
      ofd_preset <= {1'b0, 15'($urandom_range(5))};
      ssh_preset <= {1'b0, 15'($urandom_range(5) + 1)};
      repeat (t == 1 ? 8 : 2) @(posedge ref_clk);
      reset <= 0;
      {pd, pp, pn, po, pf, ps, tk, eo, ef, es, xo, xf, xs} = '0;
      repeat (300) step();
      $display("test %0d done, %0d comparisons", t, n_tests);
    end
    results();
  end
  initial begin
    #2000000;
    n_fail++;
    $display("Error %0t: run hung", $time);
    results();
  end
endmodule : testbench
bind spt_units spt_units_props #(.TICK_CYCLES(TICK_CYCLES)) spt_units_props_i (.*);
`default_nettype wire
